//--- hdl/rlf_pkg.sv
// package of register indices, field positions, reset values and states of the event flag block
package rlf_pkg;

    // ==========================================================
    // bus and register widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;
    localparam int IDX_W  = 10;
    localparam int KIND_W = 4;

    // ==========================================================
    // register indices; the byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_TIMER_SUB  = 10'h028;
    localparam logic [IDX_W-1:0] IDX_RSVD_A     = 10'h029;
    localparam logic [IDX_W-1:0] IDX_LINK_STAT  = 10'h02A;
    localparam logic [IDX_W-1:0] IDX_FRAME_STAT = 10'h02B;
    localparam logic [IDX_W-1:0] IDX_LINK_MASK  = 10'h02C;
    localparam logic [IDX_W-1:0] IDX_FRAME_MASK = 10'h02D;
    localparam logic [IDX_W-1:0] IDX_RSVD_B     = 10'h02E;
    localparam logic [IDX_W-1:0] IDX_LINK_CLR   = 10'h080;
    localparam logic [IDX_W-1:0] IDX_FRAME_CLR  = 10'h081;
    localparam logic [IDX_W-1:0] IDX_CTRL       = 10'h082;

    // ==========================================================
    // link event status / mask bit positions
    localparam int LNK_SCAN_END   = 7;
    localparam int LNK_DATA_AVAIL = 6;
    localparam int LNK_WAKE       = 5;
    localparam int LNK_STREAM     = 4;
    localparam int LNK_UNKNOWN_ID = 3;
    localparam int LNK_CRC_FAIL   = 2;
    localparam int LNK_TIMER      = 1;
    localparam int LNK_RSVD       = 0;

    // ==========================================================
    // frame event status / mask bit positions
    localparam int FRM_TX_DONE  = 7;
    localparam int FRM_TX_START = 6;
    localparam int FRM_RX_DONE  = 5;
    localparam int FRM_RX_START = 4;
    localparam int FRM_KIND_LSB = 0;

    // ==========================================================
    // control register bit positions
    localparam int CTRL_LONG_SCAN = 0;

    // ==========================================================
    // reset values
    localparam logic [REG_W-1:0]        FLAG_RST   = 8'h00;
    localparam logic [REG_W-1:0]        MASK_RST   = 8'h00;
    localparam logic [REG_W-1:0]        CTRL_RST   = 8'h00;
    localparam logic [DATA_W-1:0]       RDATA_RST  = 32'h00000000;
    localparam logic [DATA_W-REG_W-1:0] UPPER_ZERO = 24'h000000;

    // ==========================================================
    // bus handshake states
    typedef enum logic [1:0] {
        APB_IDLE   = 2'b01,
        APB_ACCESS = 2'b10
    } rlf_apb_state_type;

endpackage

//--- hdl/rlf_flag_bank.sv
// sticky flag bank in which a set always wins over a clear in the same cycle
`timescale 1ns/1ns
module rlf_flag_bank
    import rlf_pkg::*;
#(
    parameter int             W       = 8,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // set and clear vectors
    input  wire logic [W-1:0] set_vec,
    input  wire logic [W-1:0] clr_vec,
    // held flags
    output logic      [W-1:0] flags
);

    logic [W-1:0] flags_reg;
    logic [W-1:0] flags_next;

    // set applied after clear so a coinciding event is kept
    assign flags_next = (flags_reg & ~clr_vec) | set_vec;
    assign flags      = flags_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags_reg <= RST_VAL;
        end else begin
            flags_reg <= flags_next;
        end
    end

endmodule

//--- hdl/rlf_apb_port.sv
// apb handshake tracker: one wait-free access phase, registered pready
`timescale 1ns/1ns
module rlf_apb_port
    import rlf_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // apb control
    input  wire logic psel,
    input  wire logic penable,
    output logic      pready,
    // strobes to the register file
    output logic      setup_pulse,
    output logic      done_pulse
);

    rlf_apb_state_type state_reg;
    rlf_apb_state_type state_next;
    logic              pready_reg;
    logic              pready_next;

    assign setup_pulse = (state_reg == APB_IDLE) & psel & ~penable;
    assign done_pulse  = (state_reg == APB_ACCESS) & psel & penable;
    assign pready      = pready_reg;

    always_comb begin
        state_next  = state_reg;
        pready_next = pready_reg;
        case (state_reg)
            APB_IDLE: begin
                if (setup_pulse) begin
                    state_next  = APB_ACCESS;
                    pready_next = 1'b1;
                end
            end
            APB_ACCESS: begin
                // a dropped select also returns to idle
                if (done_pulse || !psel) begin
                    state_next  = APB_IDLE;
                    pready_next = 1'b0;
                end
            end
            default: begin
                state_next  = APB_IDLE;
                pready_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg  <= APB_IDLE;
            pready_reg <= 1'b0;
        end else begin
            state_reg  <= state_next;
            pready_reg <= pready_next;
        end
    end

endmodule

//--- hdl/rlf_event_flags.sv
// top of the radio link event flag block: flags, masks, interrupt and apb registers
`timescale 1ns/1ns
module rlf_event_flags
    import rlf_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    // timer sub-events, one-cycle pulses
    input  wire logic [REG_W-1:0]  timer_evt,
    // link manager events, one-cycle pulses
    input  wire logic              scan_period_end,
    input  wire logic              data_ready_evt,
    input  wire logic              wake_evt,
    input  wire logic              stream_evt,
    input  wire logic              unknown_identifier_evt,
    input  wire logic              crc_fail_evt,
    // packet engine events, one-cycle pulses
    input  wire logic              tx_crc_sent,
    input  wire logic              tx_preamble_sent,
    input  wire logic              rx_frame_done,
    input  wire logic              rx_preamble_seen,
    input  wire logic [KIND_W-1:0] reply_rx_evt,
    input  wire logic [KIND_W-1:0] reply_tx_evt,
    // outputs to the system
    output logic                   long_scan,
    output logic                   irq
);

    // ==========================================================
    // declarations
    logic              setup_pulse;
    logic              done_pulse;
    logic [IDX_W-1:0]  word_idx;
    logic              wr_done;
    logic              rd_done;

    logic              hit_timer;
    logic              hit_rsvd;
    logic              hit_link_stat;
    logic              hit_frame_stat;
    logic              hit_link_mask;
    logic              hit_frame_mask;
    logic              hit_link_clr;
    logic              hit_frame_clr;
    logic              hit_ctrl;
    logic              hit_any;

    logic [REG_W-1:0]  timer_flags;
    logic [REG_W-1:0]  timer_clr;
    logic [REG_W-1:0]  link_flags;
    logic [REG_W-1:0]  link_set;
    logic [REG_W-1:0]  link_clr;
    logic [REG_W-1:0]  link_view;
    logic [REG_W-1:0]  frame_flags;
    logic [REG_W-1:0]  frame_set;
    logic [REG_W-1:0]  frame_clr;

    logic [REG_W-1:0]  link_mask_reg;
    logic [REG_W-1:0]  link_mask_next;
    logic [REG_W-1:0]  frame_mask_reg;
    logic [REG_W-1:0]  frame_mask_next;
    logic [REG_W-1:0]  ctrl_reg;
    logic [REG_W-1:0]  ctrl_next;

    logic [REG_W-1:0]  rd_byte;
    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] prdata_next;
    logic              pslverr_reg;
    logic              pslverr_next;
    logic              timer_read_reg;
    logic              timer_read_next;
    logic              irq_reg;
    logic              irq_next;
    logic              long_scan_reg;

    // ==========================================================
    // bus handshake
    rlf_apb_port u_apb (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .psel        (psel),
        .penable     (penable),
        .pready      (pready),
        .setup_pulse (setup_pulse),
        .done_pulse  (done_pulse)
    );

    // ==========================================================
    // address decode
    assign word_idx       = paddr[ADDR_W-1:2];
    assign wr_done        = done_pulse & pwrite;
    assign rd_done        = done_pulse & ~pwrite;
    assign hit_timer      = (word_idx == IDX_TIMER_SUB);
    assign hit_rsvd       = (word_idx == IDX_RSVD_A) | (word_idx == IDX_RSVD_B);
    assign hit_link_stat  = (word_idx == IDX_LINK_STAT);
    assign hit_frame_stat = (word_idx == IDX_FRAME_STAT);
    assign hit_link_mask  = (word_idx == IDX_LINK_MASK);
    assign hit_frame_mask = (word_idx == IDX_FRAME_MASK);
    assign hit_link_clr   = (word_idx == IDX_LINK_CLR);
    assign hit_frame_clr  = (word_idx == IDX_FRAME_CLR);
    assign hit_ctrl       = (word_idx == IDX_CTRL);
    assign hit_any        = hit_timer | hit_rsvd | hit_link_stat
                          | hit_frame_stat | hit_link_mask
                          | hit_frame_mask | hit_link_clr
                          | hit_frame_clr | hit_ctrl;

    // ==========================================================
    // timer sub-event flags
    // only the bits captured for the read are cleared, so an event
    // landing between capture and completion still stays visible
    assign timer_clr = (rd_done & timer_read_reg)
                     ? prdata_reg[REG_W-1:0] : FLAG_RST;

    rlf_flag_bank #(
        .W       (REG_W),
        .RST_VAL (FLAG_RST)
    ) u_timer_flags (
        .clk_sys (clk_sys),
        .rst     (rst),
        .set_vec (timer_evt),
        .clr_vec (timer_clr),
        .flags   (timer_flags)
    );

    // ==========================================================
    // link event flags
    assign link_set[LNK_SCAN_END]   = scan_period_end
                                    & ~long_scan_reg;
    assign link_set[LNK_DATA_AVAIL] = data_ready_evt;
    assign link_set[LNK_WAKE]       = wake_evt;
    assign link_set[LNK_STREAM]     = stream_evt;
    assign link_set[LNK_UNKNOWN_ID] = unknown_identifier_evt;
    assign link_set[LNK_CRC_FAIL]   = crc_fail_evt;
    // timer summary and reserved bit are never latched here
    assign link_set[LNK_TIMER]      = 1'b0;
    assign link_set[LNK_RSVD]       = 1'b0;

    assign link_clr = wr_done & hit_link_clr ? pwdata[REG_W-1:0] : FLAG_RST;

    rlf_flag_bank #(
        .W       (REG_W),
        .RST_VAL (FLAG_RST)
    ) u_link_flags (
        .clk_sys (clk_sys),
        .rst     (rst),
        .set_vec (link_set),
        .clr_vec (link_clr),
        .flags   (link_flags)
    );

    // summary bit follows the timer flags directly, so it drops
    // exactly when the last timer flag is read away
    always_comb begin
        link_view            = link_flags;
        link_view[LNK_TIMER] = |timer_flags;
        link_view[LNK_RSVD]  = 1'b0;
    end

    // ==========================================================
    // frame event flags
    always_comb begin
        frame_set               = FLAG_RST;
        frame_set[FRM_TX_DONE]  = tx_crc_sent;
        frame_set[FRM_TX_START] = tx_preamble_sent;
        frame_set[FRM_RX_DONE]  = rx_frame_done;
        frame_set[FRM_RX_START] = rx_preamble_seen;
        // reply kinds: nar, nak, acp, ack from high to low bit
        frame_set[FRM_KIND_LSB +: KIND_W] = reply_rx_evt
                                          | reply_tx_evt;
    end

    assign frame_clr = wr_done & hit_frame_clr ? pwdata[REG_W-1:0] : FLAG_RST;

    rlf_flag_bank #(
        .W       (REG_W),
        .RST_VAL (FLAG_RST)
    ) u_frame_flags (
        .clk_sys (clk_sys),
        .rst     (rst),
        .set_vec (frame_set),
        .clr_vec (frame_clr),
        .flags   (frame_flags)
    );

    // ==========================================================
    // masks and control
    assign link_mask_next  = wr_done & hit_link_mask
                           ? pwdata[REG_W-1:0] : link_mask_reg;
    assign frame_mask_next = wr_done & hit_frame_mask
                           ? pwdata[REG_W-1:0] : frame_mask_reg;
    assign ctrl_next       = wr_done & hit_ctrl
                           ? pwdata[REG_W-1:0] : ctrl_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            link_mask_reg  <= MASK_RST;
            frame_mask_reg <= MASK_RST;
            ctrl_reg       <= CTRL_RST;
            long_scan_reg  <= 1'b0;
        end else begin
            link_mask_reg  <= link_mask_next;
            frame_mask_reg <= frame_mask_next;
            ctrl_reg       <= ctrl_next;
            long_scan_reg  <= ctrl_next[CTRL_LONG_SCAN];
        end
    end

    assign long_scan = long_scan_reg;

    // ==========================================================
    // interrupt request
    // a mask bit of one lets its flag through; masked flags still latch
    assign irq_next = |(link_view & link_mask_reg)
                    | |(frame_flags & frame_mask_reg);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign irq = irq_reg;

    // ==========================================================
    // read path
    // data is captured in the setup cycle so prdata is a flop output;
    // the clear registers are write-only and read as zero
    assign rd_byte = hit_timer      ? timer_flags
                   : hit_link_stat  ? link_view
                   : hit_frame_stat ? frame_flags
                   : hit_link_mask  ? link_mask_reg
                   : hit_frame_mask ? frame_mask_reg
                   : hit_ctrl       ? ctrl_reg
                   : FLAG_RST;

    assign prdata_next     = setup_pulse ? {UPPER_ZERO, rd_byte} : prdata_reg;
    assign pslverr_next    = setup_pulse ? ~hit_any : pslverr_reg;
    assign timer_read_next = setup_pulse ? (hit_timer & ~pwrite)
                                         : timer_read_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata_reg     <= RDATA_RST;
            pslverr_reg    <= 1'b0;
            timer_read_reg <= 1'b0;
        end else begin
            prdata_reg     <= prdata_next;
            pslverr_reg    <= pslverr_next;
            timer_read_reg <= timer_read_next;
        end
    end

    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;

endmodule

//--- sim/rlf_host_model.sv
// apb master standing in for the host controller that reads the event registers
`timescale 1ns/1ns
module rlf_host_model
    import rlf_pkg::*;
(
    // clock
    input  wire logic              clk_sys,
    // apb master side
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic      [ADDR_W-1:0] paddr,
    output logic      [DATA_W-1:0] pwdata,
    input  wire logic [DATA_W-1:0] prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
    end

    // ==========================================================
    // one transfer; the request stands until pready is seen at an edge
    task automatic xfer(input logic w, input logic [IDX_W-1:0] idx,
                        input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd,
                        output logic err);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // a released bus must not keep showing the old word
        paddr   <= ~paddr;
        pwdata  <= ~wd;
        if (n >= 20) begin
            testbench.miscompares++;
            testbench.give_verdict();
        end
    endtask
endmodule

//--- sim/rlf_event_flags_monitor.sv
// concurrent checks on the ports of the event flag block
`timescale 1ns/1ns
module rlf_event_flags_monitor
    import rlf_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // apb
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic              pready,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    // events
    input  wire logic [REG_W-1:0]  timer_evt,
    input  wire logic              scan_period_end,
    input  wire logic              crc_fail_evt,
    input  wire logic              tx_crc_sent,
    input  wire logic              rx_preamble_seen,
    input  wire logic [KIND_W-1:0] reply_rx_evt,
    input  wire logic [KIND_W-1:0] reply_tx_evt,
    // outputs
    input  wire logic              long_scan,
    input  wire logic              irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ==========================================================
    // shadow of the mask registers, taken from completed writes
    logic             wr_done;
    logic [REG_W-1:0] lm_reg;
    logic [REG_W-1:0] fm_reg;
    logic [REG_W-1:0] lm_next;
    logic [REG_W-1:0] fm_next;
    assign wr_done = psel && penable && pready && pwrite;
    assign lm_next = (wr_done && paddr[ADDR_W-1:2] == IDX_LINK_MASK) ? pwdata[7:0] : lm_reg;
    assign fm_next = (wr_done && paddr[ADDR_W-1:2] == IDX_FRAME_MASK) ? pwdata[7:0] : fm_reg;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lm_reg <= MASK_RST;
            fm_reg <= MASK_RST;
        end else begin
            lm_reg <= lm_next;
            fm_reg <= fm_next;
        end
    end

    // ==========================================================
    // enabled events reach irq two edges after the pulse
    property p_timer_irq;
        (timer_evt != 8'h00 && lm_reg[LNK_TIMER]) |-> ##2 irq;
    endproperty
    a_timer_irq: assert property (p_timer_irq) else $error("timer event lost");
    property p_scan_irq;
        (scan_period_end && !long_scan && lm_reg[LNK_SCAN_END]) |-> ##2 irq;
    endproperty
    a_scan_irq: assert property (p_scan_irq) else $error("scan end lost");
    property p_crc_irq;
        (crc_fail_evt && lm_reg[LNK_CRC_FAIL]) |-> ##2 irq;
    endproperty
    a_crc_irq: assert property (p_crc_irq) else $error("crc failure lost");
    property p_txdone_irq;
        (tx_crc_sent && fm_reg[FRM_TX_DONE]) |=> ##1 irq;
    endproperty
    a_txdone_irq: assert property (p_txdone_irq) else $error("tx done lost");
    property p_rxstart_irq;
        (rx_preamble_seen && fm_reg[FRM_RX_START]) |-> ##[2:2] irq;
    endproperty
    a_rxstart_irq: assert property (p_rxstart_irq) else $error("rx start lost");
    property p_notready_irq;
        (reply_rx_evt[3] && fm_reg[3]) |-> ##2 irq;
    endproperty
    a_notready_irq: assert property (p_notready_irq) else $error("not-ready lost");
    property p_ack_irq;
        (reply_tx_evt[0] && fm_reg[0]) |=> ##1 irq;
    endproperty
    a_ack_irq: assert property (p_ack_irq) else $error("ack lost");
    // all masked for two edges: irq has had time to fall and must stay low
    property p_masked_quiet;
        (lm_reg == 8'h00 && fm_reg == 8'h00 && $past(lm_reg | fm_reg) == 8'h00) |-> !irq;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("masked irq seen");
endmodule

bind rlf_event_flags rlf_event_flags_monitor mon (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .paddr(paddr), .pwdata(pwdata), .timer_evt(timer_evt),
    .scan_period_end(scan_period_end), .crc_fail_evt(crc_fail_evt),
    .tx_crc_sent(tx_crc_sent), .rx_preamble_seen(rx_preamble_seen),
    .reply_rx_evt(reply_rx_evt), .reply_tx_evt(reply_tx_evt),
    .long_scan(long_scan), .irq(irq));

//--- sim/testbench.sv
// self-checking bench of the radio link event flag block
`timescale 1ns/1ns
module testbench;
    import rlf_pkg::*;
    logic              clk_sys;
    logic              rst;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic              pready;
    logic              pslverr;
    logic              long_scan;
    logic              irq;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic [25:0]       ev;
    int                miscompares;
    int                checked;

    // ==========================================================
    // design and host
    rlf_event_flags dut (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_evt(ev[7:0]), .crc_fail_evt(ev[8]), .unknown_identifier_evt(ev[9]),
        .stream_evt(ev[10]), .wake_evt(ev[11]), .data_ready_evt(ev[12]),
        .scan_period_end(ev[13]), .rx_preamble_seen(ev[14]), .rx_frame_done(ev[15]),
        .tx_preamble_sent(ev[16]), .tx_crc_sent(ev[17]), .reply_rx_evt(ev[21:18]),
        .reply_tx_evt(ev[25:22]), .long_scan(long_scan), .irq(irq));
    rlf_host_model host (
        .clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // access and compare tasks
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [REG_W-1:0] d);
        logic [DATA_W-1:0] rd;
        logic              e;
        host.xfer(1'b1, idx, {UPPER_ZERO, d}, rd, e);
    endtask
    task automatic rc(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] exp, input logic ee);
        logic [DATA_W-1:0] rd;
        logic              e;
        host.xfer(1'b0, idx, '0, rd, e);
        chk(rd, exp);
        chk({31'h0, e}, {31'h0, ee});
    endtask
    task automatic pulse(input logic [25:0] v);
        @(posedge clk_sys);
        ev <= v;
        @(posedge clk_sys);
        ev <= '0;
    endtask
    // looked at mid-cycle so the registered irq has settled
    task automatic irq_is(input logic exp);
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk({31'h0, irq}, {31'h0, exp});
    endtask
    task automatic give_verdict();
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        static logic [IDX_W-1:0] regs [10] = '{IDX_TIMER_SUB, IDX_RSVD_A, IDX_LINK_STAT,
            IDX_FRAME_STAT,
            IDX_LINK_MASK, IDX_FRAME_MASK, IDX_RSVD_B, IDX_LINK_CLR, IDX_FRAME_CLR, IDX_CTRL};
        logic [REG_W-1:0] lx;
        logic [REG_W-1:0] fx;
        int               k;
        int               p;
        miscompares = 0;
        checked = 0;
        rst = 1'b1;
        ev = '0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (regs[i]) rc(regs[i], 32'h0, 1'b0);
        wr(IDX_RSVD_A, 8'hFF);
        wr(IDX_LINK_STAT, 8'hFF);
        rc(IDX_RSVD_A, 32'h0, 1'b0);
        rc(IDX_LINK_STAT, 32'h0, 1'b0);
        rc(10'h0C0, 32'h0, 1'b1);
        // pass 0 all masked, pass 1 all but the reserved link bit enabled; one event source at a time
        for (p = 0; p < 2; p++) begin
            wr(IDX_LINK_MASK, p ? 8'hFE : MASK_RST);
            wr(IDX_FRAME_MASK, p ? 8'hFF : MASK_RST);
            rc(IDX_LINK_MASK, p ? 32'hFE : 32'h0, 1'b0);
            rc(IDX_FRAME_MASK, p ? 32'hFF : 32'h0, 1'b0);
            for (k = 8; k < 26; k++) begin
                lx = (k < 14) ? 8'(1 << (k - 6)) : 8'h00;
                fx = (k < 14) ? 8'h00 : (k < 18) ? 8'(1 << (k - 10)) : 8'(1 << ((k - 18) % 4));
                pulse(26'(1) << k);
                rc(IDX_LINK_STAT, {UPPER_ZERO, lx}, 1'b0);
                rc(IDX_FRAME_STAT, {UPPER_ZERO, fx}, 1'b0);
                irq_is(p[0]);
                wr(IDX_LINK_CLR, 8'hFF);
                wr(IDX_FRAME_CLR, 8'hFF);
                irq_is(1'b0);
            end
        end
        // timer flags summarised in the link status and cleared by reading them
        wr(IDX_LINK_MASK, 8'h02);
        wr(IDX_FRAME_MASK, MASK_RST);
        pulse(26'h00000A5);
        rc(IDX_LINK_STAT, 32'h02, 1'b0);
        irq_is(1'b1);
        rc(IDX_TIMER_SUB, 32'hA5, 1'b0);
        rc(IDX_TIMER_SUB, 32'h00, 1'b0);
        rc(IDX_LINK_STAT, 32'h00, 1'b0);
        irq_is(1'b0);
        // an event that meets the read-clear of its own bit must stay set
        pulse(26'h0000001);
        fork
            rc(IDX_TIMER_SUB, 32'h01, 1'b0);
            begin
                repeat (2) @(posedge clk_sys);
                ev <= 26'h0000001;
                @(posedge clk_sys);
                ev <= '0;
            end
        join
        rc(IDX_TIMER_SUB, 32'h01, 1'b0);
        rc(IDX_TIMER_SUB, 32'h00, 1'b0);
        // a prolonged scan does not flag its end
        wr(IDX_CTRL, 8'h01);
        rc(IDX_CTRL, 32'h01, 1'b0);
        chk({31'h0, long_scan}, 32'h1);
        pulse(26'h0002000);
        rc(IDX_LINK_STAT, 32'h00, 1'b0);
        wr(IDX_CTRL, 8'h00);
        give_verdict();
    end
endmodule
